// [logic/iotg_edge_det.sv]
`timescale 1ns/1ps
// registered edge detector for an input sampled on clk
module iotg_edge_det
  import iotg_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic sig_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic [HIST_W-1:0] hist;
  logic [HIST_W-1:0] next_hist;

  // shift history
  always_comb begin
    next_hist = {hist[0], sig_in};
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hist <= HIST_RESET;
    end else begin
      hist <= next_hist;
    end
  end

  // edges from the registered history
  always_comb begin
    level = hist[0];
    rise  = hist[0] & ~hist[1];
    fall  = ~hist[0] & hist[1];
  end
endmodule

// [logic/iotg_guard_clear.sv]
`timescale 1ns/1ps
// Overview of operation
// R01 - enable low holds guard in reset
// R02 - stray set: guard sets on phase-B fall
// R03 - phase-B rise with guard clears enable
// R04 - enable low resets guard at once
// R05 - clear outputs release on next phase-B fall
// R06 - one master period delay protects reception
// R07 - divide master clock into two phases
// R08 - buffered master clock on output pin
// R09 - clear input resets the divider, clearing action, enable and guard flip-flops
// R10 - clear in receive forces strobe low
// R11 - transmit: clear waits for direction high
// R12 - direction high receive, low transmit
// R13 - receive: enable toggles on strobe fall
// R14 - legal transfers clock enable evenly
// R15 - phase edges are enables, one clock
module iotg_guard_clear
  import iotg_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic diff_master_clock_in,
  input  wire logic clear_n,
  input  wire logic direction_in,
  input  wire logic data_strobe,
  input  wire logic tx_set_enable,
  output logic      master_clock_out,
  output logic      phase_a_n,
  output logic      phase_b_n,
  output logic      bus_side_strobe,
  output logic      enable_clear_n,
  output logic      enable_clear,
  output logic      guard_set_n,
  output logic      bus_strobe_enable_ff,
  output logic      receive_mode
);
  logic mclk_level;
  logic mclk_rise;
  logic strobe_fall;
  logic phase;
  logic next_phase;
  logic guard;
  logic next_guard;
  logic enb;
  logic next_enb;
  logic clr_act;
  logic next_clr_act;
  logic next_strobe;
  logic phase_b_rise;
  logic phase_b_fall;
  logic rx_mode;

  // master clock sampled as level and rising edge
  iotg_edge_det u_mclk (
    .clk     (clk),
    .sys_rst (sys_rst),
    .sig_in  (diff_master_clock_in),
    .level   (mclk_level),
    .rise    (mclk_rise),
    .fall    ()
  );

  // data strobe falling edge
  iotg_edge_det u_strobe (
    .clk     (clk),
    .sys_rst (sys_rst),
    .sig_in  (data_strobe),
    .level   (),
    .rise    (),
    .fall    (strobe_fall)
  );

  // R12 direction decode
  assign rx_mode = (direction_in == DIR_RECEIVE);

  // R15 phase edges as enables
  assign phase_b_rise = mclk_rise & ~phase;
  assign phase_b_fall = mclk_rise & phase;

  // divider next state
  // phase flips on every sampled master rise while clear_n is high
  always_comb begin
    // R07 half-rate divider
    next_phase = mclk_rise ? ~phase : phase;
    // R09 clear parks the divider
    if (!clear_n) begin
      next_phase = PHASE_RESET;
    end
  end

  // divider register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase <= PHASE_RESET;
    end else begin
      phase <= next_phase;
    end
  end

  // clearing action next state
  // set and release never meet: they sit one master period apart
  always_comb begin
    next_clr_act = clr_act;
    // R03 clear enable on phase-B rise
    if (guard && phase_b_rise) begin
      next_clr_act = 1'b1;
    end
    // R05 release clear on phase-B fall
    if (clr_act && phase_b_fall) begin
      next_clr_act = 1'b0;
    end
    // R09 clear drops a pending action
    if (!clear_n) begin
      next_clr_act = 1'b0;
    end
  end

  // clearing action register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clr_act <= 1'b0;
    end else begin
      clr_act <= next_clr_act;
    end
  end

  // enable flip-flop next state
  // a clearing action must win, else a stray edge could re-arm it
  always_comb begin
    next_enb = enb;
    // R13 toggle on strobe fall in receive
    if (rx_mode && strobe_fall) begin
      next_enb = ~enb;
    end else if (!rx_mode && tx_set_enable) begin
      next_enb = 1'b1;
    end
    // R03 clearing wins over toggle
    if (next_clr_act) begin
      next_enb = ENB_RESET;
    end
    // R09 clear resets the enable
    if (!clear_n) begin
      next_enb = ENB_RESET;
    end
  end

  // enable register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      enb <= ENB_RESET;
    end else begin
      enb <= next_enb;
    end
  end

  // guard next state
  // only a receive enable is policed, a transmit one must survive
  always_comb begin
    next_guard = guard;
    // R02 R06 guard sets on phase-B fall
    if (rx_mode && enb && phase_b_fall && !clr_act) begin
      next_guard = 1'b1;
    end
    // R01 R04 enable low forces guard reset
    if (!next_enb) begin
      next_guard = GUARD_RESET;
    end
    // R09 clear resets the guard
    if (!clear_n) begin
      next_guard = GUARD_RESET;
    end
  end

  // guard register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      guard <= GUARD_RESET;
    end else begin
      guard <= next_guard;
    end
  end

  // bus-side strobe
  always_comb begin
    next_strobe = bus_side_strobe;
    if (rx_mode) begin
      // R10 R13 inverted enable, low on clear
      next_strobe = clear_n ? ~next_enb : 1'b0;
    end
    // R11 transmit leaves the line untouched
  end

  // R06 R09 register state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_side_strobe      <= 1'b1;
      master_clock_out     <= 1'b0;
      phase_a_n            <= 1'b1;
      phase_b_n            <= 1'b0;
      enable_clear_n       <= 1'b1;
      enable_clear         <= 1'b0;
      guard_set_n          <= 1'b1;
      bus_strobe_enable_ff <= ENB_RESET;
      receive_mode         <= 1'b0;
    end else begin
      bus_side_strobe      <= next_strobe;
      // R08 buffered master clock
      master_clock_out     <= mclk_level;
      phase_a_n            <= ~next_phase;
      phase_b_n            <= next_phase;
      enable_clear_n       <= ~next_clr_act;
      enable_clear         <= next_clr_act;
      guard_set_n          <= ~next_guard;
      bus_strobe_enable_ff <= next_enb;
      receive_mode         <= rx_mode;
    end
  end
endmodule

// [shared/iotg_pkg.sv]
package iotg_pkg;
  // mode select level on the direction input
  localparam logic DIR_RECEIVE  = 1'b1;
  localparam logic DIR_TRANSMIT = 1'b0;
  // reset values of internal flip-flops
  localparam logic ENB_RESET    = 1'b0;
  localparam logic GUARD_RESET  = 1'b0;
  localparam logic PHASE_RESET  = 1'b0;
  // width of the edge history kept for the master clock and data strobe samples
  localparam int   HIST_W       = 2;
  localparam logic [HIST_W-1:0] HIST_RESET = 2'h0;
endpackage

// [test/iotg_guard_clear_asserts.sv]
`timescale 1ns/1ps
// checks on the guard, clear and clock outputs
module iotg_guard_clear_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic diff_master_clock_in,
  input wire logic clear_n,
  input wire logic direction_in,
  input wire logic master_clock_out,
  input wire logic phase_a_n,
  input wire logic phase_b_n,
  input wire logic bus_side_strobe,
  input wire logic enable_clear_n,
  input wire logic enable_clear,
  input wire logic guard_set_n,
  input wire logic bus_strobe_enable_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_p01; !bus_strobe_enable_ff |-> guard_set_n; endproperty
  a_p01: assert property (p_p01) else $error("guard set while enable low");
  property p_p02; $fell(guard_set_n) |-> bus_strobe_enable_ff && enable_clear_n; endproperty
  a_p02: assert property (p_p02) else $error("guard set bad");
  property p_p03; $fell(enable_clear_n) |-> !bus_strobe_enable_ff && $past(!guard_set_n); endproperty
  a_p03: assert property (p_p03) else $error("clear without guard");
  property p_p05; !enable_clear_n |-> enable_clear ##[1:8] enable_clear_n; endproperty
  a_p05: assert property (p_p05) else $error("clear pair bad");
  property p_p07; phase_a_n != phase_b_n; endproperty
  a_p07: assert property (p_p07) else $error("phases not complementary");
  property p_p08;
    (clear_n && !sys_rst)[*3] |-> master_clock_out == $past(diff_master_clock_in, 2);
  endproperty
  a_p08: assert property (p_p08) else $error("master copy wrong");
  property p_p10; (!clear_n && direction_in)[*3] |-> !bus_side_strobe; endproperty
  a_p10: assert property (p_p10) else $error("strobe not low in clear");
  property p_p11; (!direction_in)[*3] |-> $stable(bus_side_strobe); endproperty
  a_p11: assert property (p_p11) else $error("strobe moved in transmit");
  property p_p13; (direction_in && clear_n)[*3] |-> bus_side_strobe != bus_strobe_enable_ff; endproperty
  a_p13: assert property (p_p13) else $error("strobe not inverse of enable");
endmodule
bind iotg_guard_clear iotg_guard_clear_asserts i_chk (.clk, .sys_rst, .diff_master_clock_in,
  .clear_n, .direction_in, .master_clock_out, .phase_a_n, .phase_b_n, .bus_side_strobe,
  .enable_clear_n, .enable_clear, .guard_set_n, .bus_strobe_enable_ff);

// [test/iotg_master_src.sv]
`timescale 1ns/1ps
// remote side master clock, free running, 200 ns period
module iotg_master_src (
  output logic mclk
);
  initial mclk = 1'b0;
  always #100 mclk = ~mclk;
endmodule

// [test/tb_iotg_guard_clear.sv]
`timescale 1ns/1ps
module tb_iotg_guard_clear;
  import iotg_pkg::*;
  logic clk = 0, sys_rst = 1, clear_n = 1, direction_in = 1, data_strobe = 0;
  logic tx_set_enable = 0, diff_master_clock_in, master_clock_out, phase_a_n, phase_b_n;
  logic bus_side_strobe, enable_clear_n, enable_clear, guard_set_n, bus_strobe_enable_ff;
  logic receive_mode, s;
  int   errors = 0, checks = 0, nclr = 0, c;
  always #25 clk = ~clk;
  iotg_master_src i_src (.mclk(diff_master_clock_in));
  iotg_guard_clear i_dut (.clk, .sys_rst, .diff_master_clock_in, .clear_n, .direction_in,
    .data_strobe, .tx_set_enable, .master_clock_out, .phase_a_n, .phase_b_n, .bus_side_strobe,
    .enable_clear_n, .enable_clear, .guard_set_n, .bus_strobe_enable_ff, .receive_mode);
  // counts cycles with the enable clear active
  always @(negedge clk) if (enable_clear_n === 1'b0 && enable_clear === 1'b1) nclr++;
  task cyc(int n); repeat (n) @(posedge clk); #1; endtask
  task chk(string n, logic e, logic v);
    checks++;
    if (v !== e) begin errors++; $display("[ERR] %s exp %b got %b", n, e, v); end
  endtask
  // one strobe fall, held apart by two cycles
  task fall(); data_strobe = 1; cyc(2); data_strobe = 0; cyc(2); endtask
  task t_stray(); c = nclr; fall();
    chk("enb set", 1, bus_strobe_enable_ff);
    cyc(20); chk("enb cleared", 0, bus_strobe_enable_ff);
    chk("clear seen", 1, nclr > c);
    chk("guard off", 1, guard_set_n);
    chk("clear off", 1, enable_clear_n);
    chk("clear hi off", 0, enable_clear);
  endtask
  task t_pair(); c = nclr; fall(); fall(); cyc(20);
    chk("pair enb", 0, bus_strobe_enable_ff);
    chk("pair no clear", 1, nclr == c);
  endtask
  task t_clear_rx(); clear_n = 0; cyc(4);
    chk("rx strobe", 0, bus_side_strobe);
    clear_n = 1; cyc(4); chk("rx strobe back", 1, bus_side_strobe);
  endtask
  task t_clear_tx(); direction_in = 0; tx_set_enable = 1; cyc(4);
    tx_set_enable = 0; s = bus_side_strobe; clear_n = 0; cyc(4);
    chk("tx strobe held", s, bus_side_strobe);
    chk("tx enb reset", 0, bus_strobe_enable_ff);
    direction_in = 1; cyc(4); chk("late strobe", 0, bus_side_strobe);
    clear_n = 1; cyc(4); chk("rx mode", 1, receive_mode);
  endtask
  task t_phase(); c = 0;
    repeat (32) begin s = phase_b_n; cyc(1); c += (s !== phase_b_n); end
    chk("phase toggles", 1, c == 8);
  endtask
  task t_mclk(); c = 0;
    repeat (32) begin s = master_clock_out; cyc(1); c += (s !== master_clock_out); end
    chk("mclk toggles", 1, c == 16);
    chk("phase pair", 1, phase_a_n !== phase_b_n);
  endtask
  task close_out();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    cyc(20); sys_rst = 0; cyc(3);
    t_stray(); t_pair(); t_clear_rx(); t_clear_tx(); t_phase(); t_mclk();
    close_out();
  end
  initial begin #100000; errors++; close_out(); end
endmodule
